// >>> watchdog_and_reset_cause_tb_top.sv
// Self-checking bench of the watchdog and reset-cause block.
`timescale 1ns/1ps
module watchdog_and_reset_cause_tb_top
  import wdr_pkg::*;
;
  localparam int BASE = 4;
  localparam int OSC  = 20;
  logic        clk_sys_in = 1'h0;
  logic        resetn_in  = 1'h0;
  logic [3:0]  awaddr     = 4'h0;
  logic [3:0]  araddr     = 4'h0;
  logic [3:0]  wstrb      = 4'h0;
  logic [31:0] wdata      = 32'h0;
  logic        awvalid    = 1'h0;
  logic        wvalid     = 1'h0;
  logic        bready     = 1'h0;
  logic        arvalid    = 1'h0;
  logic        rready     = 1'h0;
  logic        fuse       = 1'h0;
  logic        restart    = 1'h0;
  logic [1:0]  brn_lvl    = 2'h0;
  logic        brn_det    = 1'h0;
  logic        poweron    = 1'h0;
  logic        pin_n      = 1'h1;
  logic        scan       = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, osc;
  logic        chip_rst, wd_pulse, wd_act;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  int          err_total = 0;
  int          tests_run = 0;
  int          pulse_cnt = 0;
  int          n;
  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] data;
    logic [1:0] resp;
    logic [7:0] rdat;
  } wdr_row_s;
  wdr_row_s   rows [11] = '{
    '{1'h0, 4'h0, 8'h00, 2'h0, 8'h00}, '{1'h0, 4'h4, 8'h00, 2'h0, 8'h00},
    '{1'h1, 4'h4, 8'hE8, 2'h0, 8'h00}, '{1'h0, 4'h4, 8'h00, 2'h0, 8'h08},
    '{1'h1, 4'h4, 8'h00, 2'h0, 8'h00}, '{1'h1, 4'h4, 8'h03, 2'h0, 8'h00},
    '{1'h0, 4'h4, 8'h00, 2'h0, 8'h08}, '{1'h1, 4'h4, 8'h18, 2'h0, 8'h00},
    '{1'h1, 4'h4, 8'h02, 2'h0, 8'h00}, '{1'h0, 4'h4, 8'h00, 2'h0, 8'h02},
    '{1'h0, 4'h8, 8'h00, 2'h2, 8'h00}};
  logic [4:0] src_exp [5] = '{5'h02, 5'h04, 5'h00, 5'h10, 5'h01};

  always #25 clk_sys_in = ~clk_sys_in;

  always @(negedge clk_sys_in)
    if (wd_pulse === 1'h1)
      pulse_cnt++;

  wdr_osc_model u_osc (.wd_osc_out(osc));

  wdr_top #(.WD_BASE_CYCLES_P(BASE), .STARTUP_CYCLES_P(4)) uut (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .wd_osc_in(osc),
    .wd_always_on_fuse_in(fuse), .wd_restart_in(restart),
    .brownout_level_fuse_in(brn_lvl), .brownout_det_in(brn_det), .poweron_in(poweron),
    .reset_pin_n_in(pin_n), .scan_reset_in(scan), .chip_reset_out(chip_rst),
    .wd_reset_pulse_out(wd_pulse), .wd_active_out(wd_act));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Handshakes are sampled at the falling edge, where every output has settled.
  // Response ready stays high between transfers, so it never toggles twice in one step.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ok;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(negedge clk_sys_in);
      ok = awready & wready;
      @(posedge clk_sys_in);
    end
    while (ok !== 1'h1);
    awvalid <= 1'h0;
    wvalid  <= 1'h0;
    do
    begin
      @(negedge clk_sys_in);
      ok = bvalid;
      r  = bresp;
      @(posedge clk_sys_in);
    end
    while (ok !== 1'h1);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ok;
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(negedge clk_sys_in);
      ok = arready;
      @(posedge clk_sys_in);
    end
    while (ok !== 1'h1);
    arvalid <= 1'h0;
    do
    begin
      @(negedge clk_sys_in);
      ok = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clk_sys_in);
    end
    while (ok !== 1'h1);
  endtask : axi_rd

  task automatic wait_run(output int k);
    k = 0;
    do
    begin
      @(negedge clk_sys_in);
      k++;
    end
    while (chip_rst !== 1'h0);
    @(posedge clk_sys_in);
  endtask : wait_run

  task automatic set_src(input int s, input logic v);
    brn_lvl <= (s == 2) ? BRN_DISABLED : 2'h0;
    case (s)
      0: pin_n <= ~v;
      1, 2: brn_det <= v;
      3: scan <= v;
      default: poweron <= v;
    endcase
  endtask : set_src

  task automatic kick();
    restart <= 1'h1;
    @(posedge clk_sys_in);
    restart <= 1'h0;
  endtask : kick

  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    err_total++;
    end_sim();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (6) @(posedge clk_sys_in);
    resetn_in <= 1'h1;
    wait_run(n);
    chk_bit(wd_act, 1'h0);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        axi_wr(rows[i].addr, {24'h0, rows[i].data}, rsp);
      else
      begin
        axi_rd(rows[i].addr, rd, rsp);
        chk_val(rd, {24'h0, rows[i].rdat});
      end
      chk_val({30'h0, rsp}, {30'h0, rows[i].resp});
    end
    $display("register table done");
    axi_wr(OFF_WD_CONTROL, 32'h1A, rsp);
    axi_rd(OFF_WD_CONTROL, rd, rsp);
    chk_val(rd, 32'h1A);
    repeat (6) @(posedge clk_sys_in);
    axi_wr(OFF_WD_CONTROL, 32'h02, rsp);
    axi_rd(OFF_WD_CONTROL, rd, rsp);
    chk_val(rd, 32'h0A);
    chk_bit(wd_act, 1'h1);
    $display("change window done");
    for (int c = 0; c < 3; c++)
    begin
      axi_wr(OFF_WD_CONTROL, 32'h18, rsp);
      axi_wr(OFF_WD_CONTROL, 32'h08 + c, rsp);
      if (c == 0)
      begin
        repeat (12)
        begin
          kick();
          repeat (30) @(posedge clk_sys_in);
        end
        chk_val(32'(pulse_cnt), 32'h0);
      end
      kick();
      n = 0;
      do
      begin
        @(negedge clk_sys_in);
        n++;
      end
      while (wd_pulse !== 1'h1);
      chk_bit(n > (BASE * OSC << c) - OSC - 3 && n < (BASE * OSC << c) + OSC, 1'h1);
      @(negedge clk_sys_in);
      chk_bit(wd_pulse, 1'h0);
      chk_bit(chip_rst, 1'h1);
      wait_run(n);
      chk_bit(n >= 4, 1'h1);
      axi_rd(OFF_RESET_CAUSE, rd, rsp);
      chk_val(rd, 32'h08);
      axi_rd(OFF_WD_CONTROL, rd, rsp);
      chk_val(rd, 32'h00);
      axi_wr(OFF_RESET_CAUSE, 32'h0, rsp);
    end
    $display("expiry done");
    for (int s = 0; s < 5; s++)
    begin
      if (s != 4)
        axi_wr(OFF_RESET_CAUSE, 32'h0, rsp);
      set_src(s, 1'h1);
      repeat (20) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk_bit(chip_rst, s != 2);
      @(posedge clk_sys_in);
      set_src(s, 1'h0);
      wait_run(n);
      axi_rd(OFF_RESET_CAUSE, rd, rsp);
      chk_val(rd, {27'h0, src_exp[s]});
    end
    axi_wr(OFF_RESET_CAUSE, 32'h1E, rsp);
    axi_rd(OFF_RESET_CAUSE, rd, rsp);
    chk_val(rd, 32'h0);
    $display("reset sources done");
    resetn_in <= 1'h0;
    fuse      <= 1'h1;
    repeat (6) @(posedge clk_sys_in);
    resetn_in <= 1'h1;
    wait_run(n);
    axi_rd(OFF_WD_CONTROL, rd, rsp);
    chk_val(rd, 32'h08);
    axi_wr(OFF_WD_CONTROL, 32'h18, rsp);
    axi_wr(OFF_WD_CONTROL, 32'h05, rsp);
    axi_rd(OFF_WD_CONTROL, rd, rsp);
    chk_val(rd, 32'h0D);
    chk_bit(wd_act, 1'h1);
    $display("level two done");
    end_sim();
  end
endmodule : watchdog_and_reset_cause_tb_top

// >>> wdr_osc_model.sv
// Model of the free-running watchdog oscillator.
`timescale 1ns/1ps
module wdr_osc_model
#(
  parameter int HALF_NS  = 500,
  parameter int PHASE_NS = 137
)
(
  output logic wd_osc_out
);
  // The odd start phase keeps its edges off the system clock edges, 12 ns after a rising edge.
  initial
  begin
    wd_osc_out = 1'h0;
    #PHASE_NS;
    forever #HALF_NS wd_osc_out = ~wd_osc_out;
  end
endmodule : wdr_osc_model

// >>> wdr_pkg.sv
// Shared constants and types of the watchdog and reset-cause block.
package wdr_pkg;

  // ****************************************************************
  // Register map (AXI4-Lite byte addresses)
  // ****************************************************************
  localparam int         AXI_ADDR_W      = 4;
  localparam logic [3:0] OFF_RESET_CAUSE = 4'h0;
  localparam logic [3:0] OFF_WD_CONTROL  = 4'h4;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  // ****************************************************************
  // Field positions and values after reset
  // ****************************************************************
  localparam int         WDC_CE_BIT      = 4;
  localparam int         WDC_EN_BIT      = 3;
  localparam int         WDC_PER_MSB     = 2;
  localparam int         WDC_PER_LSB     = 0;
  localparam logic [2:0] WDC_PER_RESET   = 3'h0;
  localparam int         RCF_POWERON     = 0;
  localparam int         RCF_PIN         = 1;
  localparam int         RCF_BROWNOUT    = 2;
  localparam int         RCF_WD          = 3;
  localparam int         RCF_SCAN        = 4;
  localparam int         RCF_W           = 5;
  localparam logic [4:0] RCF_RESET_VAL   = 5'h00;
  localparam logic [4:0] RCF_AFTER_POR   = 5'h01;
  localparam logic [1:0] BRN_DISABLED    = 2'h3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int         SYS_PERIOD_NS    = 50;
  localparam int         WD_OSC_HZ        = 1000000;
  localparam logic [2:0] WD_CE_CYCLES     = 3'h4;
  localparam int         RST_MIN_WIDTH_NS = 800;
  localparam int         RST_MIN_CYCLES   = (RST_MIN_WIDTH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [4:0] RST_FILT_MAX     = 5'(RST_MIN_CYCLES);
  localparam int         WD_BASE_CYCLES   = 16384;
  localparam int         STARTUP_CYCLES   = 1024;
  localparam int         WD_CNT_W         = 22;
  localparam int         STARTUP_CNT_W    = 16;

  typedef enum logic [1:0] {
    RS_RUN   = 2'b00,
    RS_HOLD  = 2'b01,
    RS_DELAY = 2'b10
  } wdr_rst_state_e;

endpackage : wdr_pkg

// >>> wdr_top.sv
// Watchdog with timed configuration sequence and reset-cause flags, AXI4-Lite.
`timescale 1ns/1ps
// Behaviour
// (RQ1) Watchdog counts cycles of its own 1 MHz oscillator, not the system clock.
// (RQ2) Watchdog counter returns to zero on restart, disable or chip reset.
// (RQ3) Watchdog expiry while enabled gives a one-system-cycle reset pulse.
// (RQ4) Start-up delay starts when the watchdog reset pulse falls.
// (RQ5) Fuse picks level 1 (starts disabled) or level 2 (always enabled).
// (RQ6) Change-enable bit clears itself four system cycles after being written one.
// (RQ7) Enable written one sets; written zero clears only while change-enable is one.
// (RQ8) Software disables by writing both bits one, then enable zero within four cycles.
// (RQ9) Period bits change only while change-enable is set.
// (RQ10) At level 2 every attempt to disable the watchdog is ignored.
// (RQ11) Period code 000 gives 16K oscillator cycles, each step doubles, 111 gives 2048K.
// (RQ12) Control bits 7 to 5 always read zero.
// (RQ13) Scan reset flag set by scan reset, cleared by power-on or writing zero.
// (RQ14) Watchdog flag set by watchdog reset, cleared by power-on or writing zero.
// (RQ15) Brown-out flag set by brown-out reset, cleared by power-on or writing zero.
// (RQ16) Pin flag set by pin reset, cleared by power-on or writing zero.
// (RQ17) Power-on flag cleared only by software writing zero.
// (RQ18) Pin low beyond minimum width resets; start-up delay runs after release.
// (RQ19) Enabled brown-out detector resets at once; start-up delay runs on recovery.
// (RQ20) Software should read then clear the reset-cause flags early after start-up.
// (RQ21) At level 1 software writes enable and period with change-enable clear within four cycles.
// (RQ22) At level 2 the enable bit always reads one.
// (RQ23) Oscillator events cross into the system domain through synchronising flip-flops.
module wdr_top
  import wdr_pkg::*;
#(
  parameter int WD_BASE_CYCLES_P = WD_BASE_CYCLES,
  parameter int STARTUP_CYCLES_P = STARTUP_CYCLES
)
(
  input  wire logic                  clk_sys_in,
  input  wire logic                  resetn_in,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output logic                       s_axi_awready_out,
  input  wire logic [31:0]           s_axi_wdata_in,
  input  wire logic [3:0]            s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output logic                       s_axi_wready_out,
  output logic [1:0]                 s_axi_bresp_out,
  output logic                       s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output logic                       s_axi_arready_out,
  output logic [31:0]                s_axi_rdata_out,
  output logic [1:0]                 s_axi_rresp_out,
  output logic                       s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  input  wire logic                  wd_osc_in,
  input  wire logic                  wd_always_on_fuse_in,
  input  wire logic                  wd_restart_in,
  input  wire logic [1:0]            brownout_level_fuse_in,
  input  wire logic                  brownout_det_in,
  input  wire logic                  poweron_in,
  input  wire logic                  reset_pin_n_in,
  input  wire logic                  scan_reset_in,
  output logic                       chip_reset_out,
  output logic                       wd_reset_pulse_out,
  output logic                       wd_active_out
);

  logic                     wr_fire;
  logic                     wr_ctrl;
  logic                     wr_flags;
  logic                     wr_mapped;
  logic                     rd_fire;
  logic                     rd_mapped;
  logic [7:0]               rd_byte;
  logic                     level2;
  logic                     ce_reg;
  logic [2:0]               ce_cnt_reg;
  logic                     en_reg;
  logic [2:0]               period_reg;
  logic [7:0]               ctrl_view;
  logic [RCF_W-1:0]         flag_set;
  logic [RCF_W-1:0]         flag_vec;
  logic [4:0]               pin_low_cnt_reg;
  logic                     pin_qual;
  logic                     brn_trip;
  logic                     wd_pulse;
  logic                     wd_clear;
  logic                     reset_src;
  wdr_rst_state_e           state_reg;
  logic [STARTUP_CNT_W-1:0] startup_cnt_reg;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  // Address and data are taken together in one cycle; a held response
  // blocks the next write, so only one write is ever outstanding.
  assign s_axi_awready_out = s_axi_awvalid_in & s_axi_wvalid_in & ~s_axi_bvalid_out;
  assign s_axi_wready_out  = s_axi_awready_out;
  assign wr_fire           = s_axi_awready_out;
  assign wr_ctrl  = wr_fire && (s_axi_awaddr_in == OFF_WD_CONTROL) && s_axi_wstrb_in[0];
  assign wr_flags = wr_fire && (s_axi_awaddr_in == OFF_RESET_CAUSE) && s_axi_wstrb_in[0];
  assign wr_mapped = (s_axi_awaddr_in == OFF_WD_CONTROL) ||
                     (s_axi_awaddr_in == OFF_RESET_CAUSE);

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready_in)
    begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  assign s_axi_arready_out = ~s_axi_rvalid_out;
  assign rd_fire           = s_axi_arvalid_in & s_axi_arready_out;
  assign rd_mapped = (s_axi_araddr_in == OFF_WD_CONTROL) ||
                     (s_axi_araddr_in == OFF_RESET_CAUSE);
  assign ctrl_view = {3'h0, ce_reg, wd_active_out, period_reg}; // RQ12 RQ22

  always_comb
  begin
    rd_byte = 8'h00;
    if (s_axi_araddr_in == OFF_WD_CONTROL)
    begin
      rd_byte = ctrl_view;
    end
    else if (s_axi_araddr_in == OFF_RESET_CAUSE)
    begin
      rd_byte = {3'h0, flag_vec};
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= {24'h00_0000, rd_byte};
      s_axi_rresp_out  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready_in)
    begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // ****************************************************************
  // Watchdog control register
  // ****************************************************************
  assign level2 = wd_always_on_fuse_in; // RQ5

  // The window opens on any write of a one and closes by itself; software
  // that misses it must start the sequence again.
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in || chip_reset_out)
    begin
      ce_reg     <= 1'b0;
      ce_cnt_reg <= 3'h0;
    end
    else if (wr_ctrl)
    begin
      ce_reg     <= s_axi_wdata_in[WDC_CE_BIT]; // RQ6 RQ8
      ce_cnt_reg <= WD_CE_CYCLES - 3'h1;
    end
    else if (ce_reg)
    begin
      if (ce_cnt_reg == 3'h0)
      begin
        ce_reg <= 1'b0; // RQ6
      end
      else
      begin
        ce_cnt_reg <= ce_cnt_reg - 3'h1;
      end
    end
  end

  // The clear tests the window as it stood before this write.
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in || chip_reset_out)
    begin
      en_reg <= 1'b0; // RQ5
    end
    else if (wr_ctrl)
    begin
      if (s_axi_wdata_in[WDC_EN_BIT])
      begin
        en_reg <= 1'b1; // RQ7
      end
      else if (ce_reg && !level2)
      begin
        en_reg <= 1'b0; // RQ7 RQ10
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in || chip_reset_out)
    begin
      period_reg <= WDC_PER_RESET;
    end
    else if (wr_ctrl && ce_reg)
    begin
      period_reg <= s_axi_wdata_in[WDC_PER_MSB:WDC_PER_LSB]; // RQ9
    end
  end

  assign wd_active_out = en_reg | level2; // RQ5 RQ10 RQ22

  // ****************************************************************
  // Watchdog timer
  // ****************************************************************
  assign wd_clear = wd_restart_in | ~wd_active_out | chip_reset_out; // RQ2

  wdr_wd_timer #(
    .BASE_CYCLES (WD_BASE_CYCLES_P)
  ) u_timer (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .wd_osc_in  (wd_osc_in),
    .clear_in   (wd_clear),
    .enable_in  (wd_active_out),
    .period_in  (period_reg),
    .expire_out (wd_pulse)
  );

  assign wd_reset_pulse_out = wd_pulse; // RQ3

  // ****************************************************************
  // Reset sources and start-up delay
  // ****************************************************************
  // Shorter pin pulses are filtered out; this is synchronous logic, so a pin
  // reset needs the system clock running to be seen.
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in || reset_pin_n_in)
    begin
      pin_low_cnt_reg <= 5'h00;
    end
    else if (pin_low_cnt_reg != RST_FILT_MAX)
    begin
      pin_low_cnt_reg <= pin_low_cnt_reg + 5'h01;
    end
  end

  assign pin_qual  = (pin_low_cnt_reg == RST_FILT_MAX) & ~reset_pin_n_in; // RQ18
  assign brn_trip  = (brownout_level_fuse_in != BRN_DISABLED) & brownout_det_in; // RQ19
  assign reset_src = poweron_in | pin_qual | brn_trip | scan_reset_in | wd_pulse;

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      state_reg       <= RS_HOLD;
      startup_cnt_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        RS_RUN:
        begin
          if (reset_src)
          begin
            state_reg <= RS_HOLD;
          end
        end
        RS_HOLD:
        begin
          if (!reset_src)
          begin
            state_reg       <= RS_DELAY; // RQ4 RQ18 RQ19
            startup_cnt_reg <= STARTUP_CNT_W'(STARTUP_CYCLES_P - 1);
          end
        end
        RS_DELAY:
        begin
          if (reset_src)
          begin
            state_reg <= RS_HOLD;
          end
          else if (startup_cnt_reg == '0)
          begin
            state_reg <= RS_RUN;
          end
          else
          begin
            startup_cnt_reg <= startup_cnt_reg - STARTUP_CNT_W'(1);
          end
        end
        default:
        begin
          state_reg <= RS_HOLD;
        end
      endcase
    end
  end

  assign chip_reset_out = (state_reg != RS_RUN);

  // ****************************************************************
  // Reset-cause flags
  // ****************************************************************
  assign flag_set = {scan_reset_in, wd_pulse, brn_trip, pin_qual, poweron_in};

  // A cause that arrives with a software clear wins; power-on wipes the rest.
  for (genvar i = 0; i < RCF_W; i++)
  begin : g_flag
    logic bit_reg;

    always_ff @(posedge clk_sys_in)
    begin
      if (!resetn_in)
      begin
        bit_reg <= RCF_RESET_VAL[i];
      end
      else if (poweron_in)
      begin
        bit_reg <= RCF_AFTER_POR[i]; // RQ13 RQ14 RQ15 RQ16 RQ17
      end
      else if (flag_set[i])
      begin
        bit_reg <= 1'b1; // RQ13 RQ14 RQ15 RQ16
      end
      else if (wr_flags && !s_axi_wdata_in[i])
      begin
        bit_reg <= 1'b0; // RQ17
      end
    end

    assign flag_vec[i] = bit_reg;
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_ce_auto_clear: assert property ( // RQ6
    (wr_ctrl && s_axi_wdata_in[WDC_CE_BIT] && !chip_reset_out)
    ##1 (!wr_ctrl && !chip_reset_out) [*4] |-> ce_reg ##1 !ce_reg)
    else $error("change enable not cleared after four cycles");

  a_en_needs_ce: assert property ( // RQ7
    (wr_ctrl && !s_axi_wdata_in[WDC_EN_BIT] && !ce_reg && en_reg && !chip_reset_out)
    |=> en_reg)
    else $error("enable cleared without change enable");

  a_lvl2_no_off: assert property ( // RQ10
    (level2 && en_reg && wr_ctrl && ce_reg && !s_axi_wdata_in[WDC_EN_BIT] && !chip_reset_out)
    |=> en_reg)
    else $error("watchdog disabled at safety level 2");

  a_lvl2_reads_one: assert property ( // RQ22
    (rd_fire && level2 && (s_axi_araddr_in == OFF_WD_CONTROL))
    |=> s_axi_rdata_out[WDC_EN_BIT] && (s_axi_rdata_out[7:5] == 3'h0))
    else $error("enable bit read zero at safety level 2");

  a_period_locked: assert property ( // RQ9
    (wr_ctrl && !ce_reg && !chip_reset_out) |=> $stable(period_reg))
    else $error("period changed outside the change window");

  a_wd_pulse_delay: assert property ( // RQ4
    (wd_pulse ##1 !reset_src) |-> chip_reset_out ##1 (state_reg == RS_DELAY))
    else $error("start-up delay did not follow watchdog pulse");

  a_wd_flag_set: assert property ( // RQ14
    (wd_pulse && !poweron_in) |=> flag_vec[RCF_WD])
    else $error("watchdog flag not set by watchdog reset");

  a_por_clears: assert property ( // RQ13
    poweron_in |=> (flag_vec == RCF_AFTER_POR) && chip_reset_out)
    else $error("power-on did not leave only the power-on flag");

  a_por_flag_kept: assert property ( // RQ17
    (flag_vec[RCF_POWERON] && !(wr_flags && !s_axi_wdata_in[RCF_POWERON]))
    |=> flag_vec[RCF_POWERON])
    else $error("power-on flag lost without a software clear");

  a_fast_resets: assert property ( // RQ19
    (brn_trip || pin_qual) |=> chip_reset_out ##1 chip_reset_out)
    else $error("brown-out or pin reset not applied at once");

  a_b_holds: assert property (
    (s_axi_bvalid_out && !s_axi_bready_in) |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped before it was taken");

endmodule : wdr_top

// >>> wdr_wd_timer.sv
// Watchdog time-out counter driven by the sampled watchdog oscillator.
`timescale 1ns/1ps
module wdr_wd_timer
  import wdr_pkg::*;
#(
  parameter int BASE_CYCLES = WD_BASE_CYCLES
)
(
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  input  wire logic       wd_osc_in,
  input  wire logic       clear_in,
  input  wire logic       enable_in,
  input  wire logic [2:0] period_in,
  output logic            expire_out
);

  logic                osc_meta_reg;
  logic                osc_sync_reg;
  logic                osc_prev_reg;
  logic                osc_tick;
  logic [WD_CNT_W-1:0] limit;
  logic [WD_CNT_W-1:0] count_reg;
  logic                at_limit;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  // ****************************************************************
  // Oscillator edge detection
  // ****************************************************************
  // The oscillator is free running and unrelated to the system clock, so its
  // level passes two flip-flops before the edge detector looks at it.
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end
    else
    begin
      osc_meta_reg <= wd_osc_in; // RQ23
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  assign osc_tick = osc_sync_reg & ~osc_prev_reg; // RQ1

  // ****************************************************************
  // Time-out counter
  // ****************************************************************
  assign limit    = WD_CNT_W'(BASE_CYCLES) << period_in; // RQ11
  // A period shortened below the running count still expires on the next tick.
  assign at_limit = (count_reg >= (limit - WD_CNT_W'(1)));

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in || clear_in)
    begin
      count_reg <= '0; // RQ2
    end
    else if (enable_in && osc_tick)
    begin
      count_reg <= at_limit ? '0 : count_reg + WD_CNT_W'(1); // RQ1
    end
  end

  // The expiry is formed in the system domain, so it is exactly one cycle.
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      expire_out <= 1'b0;
    end
    else
    begin
      expire_out <= enable_in && osc_tick && at_limit && !clear_in; // RQ3 RQ23
    end
  end

  a_expire_single: assert property ( // RQ3
    expire_out |=> !expire_out)
    else $error("watchdog expiry lasted more than one cycle");

  a_clear_zeroes: assert property ( // RQ2
    clear_in |=> (count_reg == '0) && !expire_out)
    else $error("watchdog counter not zero after clear");

endmodule : wdr_wd_timer
